// File: spp_top.sv
/*
 Serial port with six shared pins behind an AHB-Lite register slave.
 Assumes a single-master bus and stop_i from core-clock logic.
*/
`timescale 1ns/1ps
module spp_top (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      hsel_i,
   input  wire logic [31:0]               haddr_i,
   input  wire logic [1:0]                htrans_i,
   input  wire logic                      hwrite_i,
   input  wire logic [2:0]                hsize_i,
   input  wire logic [31:0]               hwdata_i,
   input  wire logic                      hready_i,
   output logic                           hreadyout_o,
   output logic                           hresp_o,
   output logic [31:0]                    hrdata_o,
   input  wire logic                      stop_i,
   input  wire logic [spp_pkg::NPIN-1:0]  pin_i,
   output logic [spp_pkg::NPIN-1:0]       pin_out_o,
   output logic [spp_pkg::NPIN-1:0]       pin_oe_n_o
);
   spp_edge_if eg ();

   spp_edge_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      (pin_i),
      .eg         (eg.src)
   );

   logic [spp_pkg::NPIN-1:0]   ctrl_ff;
   logic [spp_pkg::NPIN-1:0]   dir_ff;
   logic [spp_pkg::NPIN-1:0]   gpd_ff;
   logic [31:0]                mode_ff;
   logic [spp_pkg::WORD_W-1:0] tx_hold_ff;
   logic                       tx_full_ff;
   logic [spp_pkg::WORD_W-1:0] tx_sh_ff;
   logic                       tx_act_ff;
   logic [spp_pkg::CNT_W-1:0]  tx_cnt_ff;
   logic [spp_pkg::WORD_W-1:0] rx_sh_ff;
   logic [spp_pkg::WORD_W-1:0] rx_hold_ff;
   logic                       rx_full_ff;
   logic                       rx_ovr_ff;
   logic                       rx_act_ff;
   logic [spp_pkg::CNT_W-1:0]  rx_cnt_ff;
   logic [8:0]                 div_cnt_ff;
   logic                       sck_int_ff;
   logic                       fs_int_ff;
   logic [spp_pkg::CNT_W-1:0]  fcnt_ff;
   logic                       dp_ff;
   logic                       dw_ff;
   logic [7:0]                 da_ff;
   logic [31:0]                hrdata_ff;
   logic [spp_pkg::NPIN-1:0]   nxt_out;
   logic [spp_pkg::NPIN-1:0]   nxt_oe_n;

   logic acc;
   logic wr;
   logic en;
   logic sync_m;
   logic int_rise;
   logic int_fall;
   logic tck_rise;
   logic rck_rise;
   logic rck_fall;
   logic tfs;
   logic rfs;
   logic tload;
   logic rdone;
   logic rd_rx;
   logic tx_bit;

   // Bus: zero-wait slave, read data captured in the address phase
   assign acc = hsel_i & htrans_i[1] & hready_i;
   assign wr  = dp_ff & dw_ff;
   assign rd_rx = acc & ~hwrite_i & (haddr_i[7:0] == spp_pkg::OFS_RX);
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_ff;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dp_ff <= 1'b0;
         dw_ff <= 1'b0;
         da_ff <= 8'h00;
      end else if (hready_i) begin
         dp_ff <= acc;
         dw_ff <= hwrite_i;
         da_ff <= haddr_i[7:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (acc && !hwrite_i) begin
         case (haddr_i[7:0])
            spp_pkg::OFS_CTRL: hrdata_ff <= {26'h0000000, ctrl_ff};
            spp_pkg::OFS_DIR:  hrdata_ff <= {26'h0000000, dir_ff};
            spp_pkg::OFS_GPD:  hrdata_ff <= {26'h0000000, eg.lvl};
            spp_pkg::OFS_MODE: hrdata_ff <= mode_ff;
            spp_pkg::OFS_RX:   hrdata_ff <= {16'h0000, rx_hold_ff};
            spp_pkg::OFS_STAT: hrdata_ff <= {29'h00000000, rx_ovr_ff, rx_full_ff, ~tx_full_ff};
            default:           hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration registers; all pins come up as inputs [R14]
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= spp_pkg::CTRL_RST;  // [R14]
         dir_ff  <= spp_pkg::DIR_RST;   // [R14]
         gpd_ff  <= '0;
         mode_ff <= spp_pkg::MODE_RST;
      end else if (wr) begin
         if (da_ff == spp_pkg::OFS_CTRL) ctrl_ff <= hwdata_i[spp_pkg::NPIN-1:0];
         if (da_ff == spp_pkg::OFS_DIR)  dir_ff  <= hwdata_i[spp_pkg::NPIN-1:0];
         if (da_ff == spp_pkg::OFS_GPD)  gpd_ff  <= hwdata_i[spp_pkg::NPIN-1:0];
         if (da_ff == spp_pkg::OFS_MODE) mode_ff <= hwdata_i;
      end
   end

   assign en     = mode_ff[spp_pkg::M_EN];
   assign sync_m = mode_ff[spp_pkg::M_SYNC];

   // Internal bit clock: half period is the divider field plus three cycles
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_ff <= 9'h000;
         sck_int_ff <= 1'b0;
      end else if (!en) begin
         div_cnt_ff <= 9'h000;
         sck_int_ff <= 1'b0;
      end else if (div_cnt_ff == 9'h000) begin
         div_cnt_ff <= {1'b0, mode_ff[spp_pkg::M_DIV_LSB +: spp_pkg::DIV_W]}
                       + spp_pkg::DIV_BASE;
         sck_int_ff <= ~sck_int_ff;
      end else begin
         div_cnt_ff <= div_cnt_ff - 9'h001;
      end
   end

   assign int_rise = en & (div_cnt_ff == 9'h000) & ~sck_int_ff;
   assign int_fall = en & (div_cnt_ff == 9'h000) & sck_int_ff;

   // Internal frame sync: high during the bit before each word
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fcnt_ff   <= '0;
         fs_int_ff <= 1'b0;
      end else if (!en) begin
         fcnt_ff   <= '0;
         fs_int_ff <= 1'b0;
      end else if (int_rise) begin
         fcnt_ff   <= (fcnt_ff == spp_pkg::WORD_LAST) ? '0 : fcnt_ff + 5'h01;
         fs_int_ff <= (fcnt_ff == spp_pkg::WORD_LAST);  // [R7]
      end
   end

   // Clock and frame sync routing; stop masks the clock and frame sync inputs, not the level read [R17]
   always_comb begin
      tck_rise = 1'b0;
      rck_rise = 1'b0;
      rck_fall = 1'b0;
      tfs      = 1'b0;
      rfs      = 1'b0;
      if (en && !stop_i) begin
         // Bit clock pin drives transmit always, receive only when sync [R9]
         if (mode_ff[spp_pkg::M_SCK_OUT]) begin
            tck_rise = int_rise;
         end else begin
            tck_rise = eg.rise[spp_pkg::PIN_SCK] & ctrl_ff[spp_pkg::PIN_SCK];  // [R20]
         end
         // Frame sync line: internal when output, pin level when input [R6] [R8]
         if (mode_ff[spp_pkg::M_FS_OUT]) begin
            tfs = fs_int_ff;
         end else begin
            tfs = eg.lvl[spp_pkg::PIN_FS];  // [R8]
         end
         if (sync_m) begin
            rck_rise = tck_rise;  // [R9]
            rck_fall = mode_ff[spp_pkg::M_SCK_OUT] ? int_fall
                       : eg.fall[spp_pkg::PIN_SCK] & ctrl_ff[spp_pkg::PIN_SCK];
            rfs      = tfs;  // [R6]
         end else if (mode_ff[spp_pkg::M_RCK_OUT]) begin
            rck_rise = int_rise;  // [R2]
            rck_fall = int_fall;
            rfs      = mode_ff[spp_pkg::M_RFS_OUT] ? fs_int_ff : eg.lvl[spp_pkg::PIN_B];
         end else begin
            rck_rise = eg.rise[spp_pkg::PIN_A] & ctrl_ff[spp_pkg::PIN_A];  // [R2]
            rck_fall = eg.fall[spp_pkg::PIN_A] & ctrl_ff[spp_pkg::PIN_A];
            rfs      = mode_ff[spp_pkg::M_RFS_OUT] ? fs_int_ff : eg.lvl[spp_pkg::PIN_B];  // [R4]
         end
      end
   end

   // Transmit and receive run independently: full duplex [R1]
   assign tload = tck_rise & tfs;
   assign tx_bit = tx_sh_ff[spp_pkg::WORD_W-1];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh_ff  <= '0;
         tx_act_ff <= 1'b0;
         tx_cnt_ff <= '0;
      end else if (tload) begin
         tx_sh_ff  <= tx_full_ff ? tx_hold_ff : '0;  // [R13]
         tx_act_ff <= 1'b1;
         tx_cnt_ff <= spp_pkg::WORD_LAST;
      end else if (tck_rise && tx_act_ff) begin
         tx_sh_ff  <= {tx_sh_ff[spp_pkg::WORD_W-2:0], 1'b0};  // [R13]
         tx_cnt_ff <= tx_cnt_ff - 5'h01;
         if (tx_cnt_ff == 5'h00) tx_act_ff <= 1'b0;
      end
   end

   // A write landing on the load cycle refills the holding word
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_hold_ff <= '0;
         tx_full_ff <= 1'b0;
      end else if (wr && da_ff == spp_pkg::OFS_TX) begin
         tx_hold_ff <= hwdata_i[spp_pkg::WORD_W-1:0];
         tx_full_ff <= 1'b1;
      end else if (tload) begin
         tx_full_ff <= 1'b0;
      end
   end

   assign rdone = rck_fall & rx_act_ff & (rx_cnt_ff == 5'h01);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_sh_ff  <= '0;
         rx_act_ff <= 1'b0;
         rx_cnt_ff <= '0;
      end else if (rck_rise && rfs && !rx_act_ff) begin
         rx_act_ff <= 1'b1;
         rx_cnt_ff <= spp_pkg::WORD_FULL;
      end else if (rck_fall && rx_act_ff) begin
         rx_sh_ff  <= {rx_sh_ff[spp_pkg::WORD_W-2:0], eg.lvl[spp_pkg::PIN_RXD]};  // [R12]
         rx_cnt_ff <= rx_cnt_ff - 5'h01;
         if (rx_cnt_ff == 5'h01) rx_act_ff <= 1'b0;
      end
   end

   // Completed word beats a same-cycle read: the flag stays set
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_hold_ff <= '0;
         rx_full_ff <= 1'b0;
         rx_ovr_ff  <= 1'b0;
      end else begin
         if (rdone) begin
            rx_hold_ff <= {rx_sh_ff[spp_pkg::WORD_W-2:0], eg.lvl[spp_pkg::PIN_RXD]};  // [R12]
            rx_full_ff <= 1'b1;
         end else if (rd_rx) begin
            rx_full_ff <= 1'b0;
         end
         if (rdone && rx_full_ff) begin
            rx_ovr_ff <= 1'b1;
         end else if (wr && da_ff == spp_pkg::OFS_STAT && hwdata_i[spp_pkg::S_ROV]) begin
            rx_ovr_ff <= 1'b0;
         end
      end
   end

   // Pin drivers; output enables are active low
   always_comb begin
      nxt_out  = gpd_ff;
      nxt_oe_n = ~dir_ff;  // [R15]
      // Serial function per pin as selected by the control bits [R16]
      if (ctrl_ff[spp_pkg::PIN_A]) begin
         if (sync_m) begin
            nxt_out[spp_pkg::PIN_A] = mode_ff[spp_pkg::M_A_FLAG] ?
                                      mode_ff[spp_pkg::M_FLAG0] : tx_bit;  // [R3]
            nxt_oe_n[spp_pkg::PIN_A] = 1'b0;
         end else begin
            nxt_out[spp_pkg::PIN_A]  = sck_int_ff;  // [R2]
            nxt_oe_n[spp_pkg::PIN_A] = ~mode_ff[spp_pkg::M_RCK_OUT];
         end
      end
      if (ctrl_ff[spp_pkg::PIN_B]) begin
         if (sync_m) begin
            nxt_out[spp_pkg::PIN_B] = mode_ff[spp_pkg::M_B_FLAG] ?
                                      mode_ff[spp_pkg::M_FLAG1] : tx_bit;  // [R5]
            nxt_oe_n[spp_pkg::PIN_B] = 1'b0;
         end else begin
            nxt_out[spp_pkg::PIN_B]  = fs_int_ff;  // [R4]
            nxt_oe_n[spp_pkg::PIN_B] = ~mode_ff[spp_pkg::M_RFS_OUT];
         end
      end
      if (ctrl_ff[spp_pkg::PIN_FS]) begin
         nxt_out[spp_pkg::PIN_FS]  = fs_int_ff;  // [R7]
         nxt_oe_n[spp_pkg::PIN_FS] = ~mode_ff[spp_pkg::M_FS_OUT];
      end
      if (ctrl_ff[spp_pkg::PIN_SCK]) begin
         nxt_out[spp_pkg::PIN_SCK]  = sck_int_ff;  // [R9]
         nxt_oe_n[spp_pkg::PIN_SCK] = ~mode_ff[spp_pkg::M_SCK_OUT];
      end
      if (ctrl_ff[spp_pkg::PIN_RXD]) begin
         nxt_out[spp_pkg::PIN_RXD]  = 1'b0;
         nxt_oe_n[spp_pkg::PIN_RXD] = 1'b1;  // [R12]
      end
      if (ctrl_ff[spp_pkg::PIN_TXD]) begin
         nxt_out[spp_pkg::PIN_TXD]  = tx_bit;  // [R13]
         nxt_oe_n[spp_pkg::PIN_TXD] = ~tx_act_ff;
      end
      // Only stop touches the drivers; wait has no input here at all [R19]
      if (stop_i) begin
         nxt_oe_n = '1;  // [R18]
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_out_o  <= '0;
         pin_oe_n_o <= '1;  // [R14]
      end else begin
         pin_out_o  <= nxt_out;
         pin_oe_n_o <= nxt_oe_n;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   gpio_dir_a: assert property (!stop_i && !ctrl_ff[3] |=> pin_oe_n_o[3] != $past(dir_ff[3])) // [R15]
      else $error("gpio direction not followed");
   stop_hiz_a: assert property (stop_i |=> &pin_oe_n_o) // [R18]
      else $error("pin driven during stop");
   stop_ignore_a: assert property (stop_i |-> !tck_rise && !rck_fall && !rck_rise) // [R17]
      else $error("input used during stop");
   rxd_input_a: assert property (ctrl_ff[4] |=> pin_oe_n_o[4]) // [R12]
      else $error("receive data pin driven");
   txd_drive_a: assert property (!stop_i && ctrl_ff[5] && tx_act_ff // [R13]
      |=> !pin_oe_n_o[5] && pin_out_o[5] == $past(tx_bit))
      else $error("transmit pin not from shift register");
   fs_drive_a: assert property (!stop_i && ctrl_ff[2] && mode_ff[2] // [R7]
      |=> !pin_oe_n_o[2] && pin_out_o[2] == $past(fs_int_ff))
      else $error("frame sync output wrong");
   flag0_a: assert property (!stop_i && ctrl_ff[0] && sync_m && mode_ff[5] // [R3]
      |=> !pin_oe_n_o[0] && pin_out_o[0] == $past(mode_ff[8]))
      else $error("flag 0 not on line A");
   shared_fs_a: assert property (sync_m && tload |=> rx_act_ff) // [R8]
      else $error("receiver not armed by shared frame sync");
   word_len_a: assert property (tload |=> tx_act_ff && tx_cnt_ff == 5'h0F) // [R8]
      else $error("load did not start a word");
   rx_word_a: assert property (rdone |=> rx_full_ff) // [R12]
      else $error("received word not flagged");
   reset_in_a: assert property ($rose(rst_n_i) |-> &pin_oe_n_o) // [R14]
      else $error("pin driven after reset");
endmodule

// File: spp_pkg.sv
/*
 Constants for the serial port pin block: pin slots, register map, field
 positions, reset values and word length. Assumes one port of six pins.

// What this block does
// R1: Port sends and receives at the same time with codecs, processors, SPI parts.
// R2: Async mode: control line A is the receive bit clock, input or output.
// R3: Sync mode: control line A is transmitter 1 output or serial flag 0.
// R4: Async mode: control line B is the receive frame sync, input or output.
// R5: Sync mode: control line B is transmitter 2 output or serial flag 1.
// R6: Frame sync line serves both directions in sync mode, transmit only in async.
// R7: Frame sync configured as output drives the internally made frame sync.
// R8: Frame sync as input comes from outside; used by transmitter, receiver if sync.
// R9: Bit clock line clocks both directions in sync mode, transmit only in async.
// R10: External bit clock may be asynchronous; period at least six core cycles.
// R11: Each half of the external bit clock spans at least three core cycles.
// R12: Receive data line is an input; bits shift into the receive register.
// R13: Transmit data line is driven from the transmit shift register while sending.
// R14: After reset all six pins are general-purpose inputs.
// R15: In general-purpose use a direction bit per pin picks input or output.
// R16: A control bit per pin switches the pin to its serial function.
// R17: In stop, a pin that was an input stays an input and is ignored.
// R18: In stop, a pin that was an output goes high impedance.
// R19: Wait state leaves every pin as it was.
// R20: External bit clock and frame sync are synchronised and edge-detected first.
*/
package spp_pkg;
   localparam int NPIN     = 6;
   localparam int PIN_A    = 0;
   localparam int PIN_B    = 1;
   localparam int PIN_FS   = 2;
   localparam int PIN_SCK  = 3;
   localparam int PIN_RXD  = 4;
   localparam int PIN_TXD  = 5;
   localparam int WORD_W   = 16;
   localparam int CNT_W    = 5;
   localparam logic [CNT_W-1:0] WORD_LAST = 5'h0F;
   localparam logic [CNT_W-1:0] WORD_FULL = 5'h10;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIR  = 8'h04;
   localparam logic [7:0] OFS_GPD  = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_TX   = 8'h10;
   localparam logic [7:0] OFS_RX   = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;

   localparam logic [NPIN-1:0] CTRL_RST = 6'h00;
   localparam logic [NPIN-1:0] DIR_RST  = 6'h00;
   localparam logic [31:0]     MODE_RST = 32'h0000_0000;

   localparam int M_SYNC    = 0;
   localparam int M_SCK_OUT = 1;
   localparam int M_FS_OUT  = 2;
   localparam int M_RCK_OUT = 3;
   localparam int M_RFS_OUT = 4;
   localparam int M_A_FLAG  = 5;
   localparam int M_B_FLAG  = 6;
   localparam int M_EN      = 7;
   localparam int M_FLAG0   = 8;
   localparam int M_FLAG1   = 9;
   localparam int M_DIV_LSB = 16;
   localparam int DIV_W     = 8;
   localparam logic [8:0] DIV_BASE = 9'h002;

   localparam int S_TXE = 0;
   localparam int S_RXF = 1;
   localparam int S_ROV = 2;
endpackage

// File: spp_edge_if.sv
/*
 Bundle of synchronised pin levels and their edges.
 Assumes producer and consumer share the core clock.
*/
`timescale 1ns/1ps
interface spp_edge_if;
   logic [spp_pkg::NPIN-1:0] lvl;
   logic [spp_pkg::NPIN-1:0] rise;
   logic [spp_pkg::NPIN-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface

// File: spp_edge_sync.sv
/*
 Two-flop synchroniser and edge detector for all pin inputs.
 Assumes external clocks keep each half at least three core cycles.
*/
`timescale 1ns/1ps
module spp_edge_sync (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic [spp_pkg::NPIN-1:0]  pin_i,
   spp_edge_if.src                        eg
);
   logic [spp_pkg::NPIN-1:0] s1_ff;
   logic [spp_pkg::NPIN-1:0] s2_ff;
   logic [spp_pkg::NPIN-1:0] s3_ff;

   // First stage feeds only the second; edges come from later stages
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_i;   // [R20]
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Halves of three cycles or more give one clean edge per transition [R11]
   assign eg.lvl  = s2_ff;
   assign eg.rise = s2_ff & ~s3_ff;  // [R20]
   assign eg.fall = ~s2_ff & s3_ff;

   sync_delay_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R20]
      ##2 (s2_ff == $past(pin_i, 2)))
      else $error("pin level not two cycles behind pin");
endmodule

// File: spp_peer.sv
/*
 Far-side serial party: makes bit clock and frame sync, sends one word.
 Assumes go_i rises once per frame and txd_i is X while the pin floats.
*/
`timescale 1ns/1ps
module spp_peer (
   input  wire logic        go_i,
   input  wire logic [15:0] word_i,
   input  wire logic        txd_i,
   output logic             sck_o,
   output logic             fs_o,
   output logic             rxd_o,
   output logic [15:0]      word_o,
   output logic             done_o
);
   initial begin
      sck_o = 1'b0;
      fs_o = 1'b0;
      rxd_o = 1'b0;
      word_o = 16'h0000;
      done_o = 1'b0;
   end
   // Clock stands still between frames; halves are 8 core cycles
   always @(posedge go_i) begin
      done_o = 1'b0;
      // Keep every pin change off the core clock edges
      #3;
      fs_o = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         #80 sck_o = 1'b1;
         rxd_o = word_i[i];
         #40 fs_o = 1'b0;
         #40 word_o[i] = txd_i;
         sck_o = 1'b0;
      end
      // Released line has no pull, so it must not keep the last bit
      #80 rxd_o = ~rxd_o;
      done_o = 1'b1;
   end
endmodule

// File: sync_serial_port_pins_bench.sv
/*
 Self-checking bench for spp_top: AHB-Lite tasks, pin scenarios, verdict.
 Assumes spp_peer on the pins and a single-slave bus.
*/
`timescale 1ns/1ps
module sync_serial_port_pins_bench;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic        hsel       = 1'b0;
   logic [31:0] haddr      = 32'h0;
   logic [1:0]  htrans     = 2'h0;
   logic        hwrite     = 1'b0;
   logic [31:0] hwdata     = 32'h0;
   logic        stop       = 1'b0;
   logic [5:0]  ext_gp     = 6'h00;
   logic        rte_s      = 1'b0;
   logic        rte_a      = 1'b0;
   logic        go         = 1'b0;
   logic [15:0] peer_tx    = 16'h0;
   logic [31:0] rd;
   wire         hrdy;
   wire         hresp;
   wire  [31:0] hrdata;
   wire  [5:0]  pin_i;
   wire  [5:0]  pout;
   wire  [5:0]  poe_n;
   wire  [5:0]  ext;
   wire         sck;
   wire         fs;
   wire         rxd;
   wire         pdone;
   wire  [15:0] pword;
   int          n_errors   = 0;
   int          num_checks = 0;

   assign ext = {ext_gp[5], (rte_s | rte_a) ? rxd : ext_gp[4], rte_s ? sck : ext_gp[3],
                 rte_s ? fs : ext_gp[2], rte_a ? fs : ext_gp[1], rte_a ? sck : ext_gp[0]};
   // Wire level: the device wins where it drives, the outside elsewhere
   assign pin_i = (~poe_n & pout) | (poe_n & ext);

   always #5 core_clk_i = ~core_clk_i;

   spp_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
      .stop_i(stop), .pin_i(pin_i), .pin_out_o(pout), .pin_oe_n_o(poe_n));

   spp_peer i_peer (.go_i(go), .word_i(peer_tx), .txd_i(poe_n[5] ? 1'bx : pout[5]),
      .sck_o(sck), .fs_o(fs), .rxd_o(rxd), .word_o(pword), .done_o(pdone));

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask

   task oechk(input logic [5:0] e, input string what);
      chk({26'h0, poe_n}, {26'h0, e}, what);
   endtask

   task frame(input logic [15:0] w);
      peer_tx = w;
      go = 1'b1;
      wait (pdone === 1'b0);
      wait (pdone === 1'b1);
      go = 1'b0;
      cyc(10);
   endtask

   task t_reset;
      oechk(6'h3F, "oe after reset");
      chk({26'h0, pout}, 32'h0, "out after reset");
      rdchk(spp_pkg::OFS_CTRL, 32'h0, "ctrl reset");
      rdchk(spp_pkg::OFS_DIR, 32'h0, "dir reset");
      rdchk(spp_pkg::OFS_MODE, spp_pkg::MODE_RST, "mode reset");
      rdchk(8'h1C, 32'h0, "unmapped read");
      chk({31'h0, hresp}, 32'h0, "okay response");
      $display("test reset done");
   endtask

   task t_gpio;
      wr(spp_pkg::OFS_DIR, 32'h15);
      ext_gp <= 6'h2A;
      wr(spp_pkg::OFS_GPD, 32'h05);
      cyc(3);
      oechk(6'h2A, "gpio direction");
      chk({26'h0, pout & 6'h15}, 32'h05, "gpio out");
      rdchk(spp_pkg::OFS_GPD, 32'h2F, "gpio levels");
      wr(spp_pkg::OFS_CTRL, 32'h20);
      wr(spp_pkg::OFS_DIR, 32'h3F);
      cyc(3);
      oechk(6'h20, "serial tx idle floats");
      stop <= 1'b1;
      cyc(3);
      oechk(6'h3F, "stop floats outputs");
      stop <= 1'b0;
      cyc(3);
      oechk(6'h20, "after stop");
      wr(spp_pkg::OFS_DIR, 32'h00);
      $display("test gpio done");
   endtask

   task t_sync;
      wr(spp_pkg::OFS_MODE, 32'h81);
      wr(spp_pkg::OFS_CTRL, 32'h3F);
      wr(spp_pkg::OFS_TX, 32'hA5C3);
      rdchk(spp_pkg::OFS_STAT, 32'h0, "tx holding full");
      rte_s <= 1'b1;
      fork
         frame(16'h3C96);
         begin
            repeat (4) @(posedge sck);
            cyc(5);
            oechk(6'h1C, "sync drivers on");
            chk({30'h0, pout[1:0]}, {30'h0, {2{pout[5]}}}, "lines copy tx");
         end
      join
      chk({16'h0, pword}, 32'hA5C3, "tx word");
      rdchk(spp_pkg::OFS_STAT, 32'h3, "stat after frame");
      rdchk(spp_pkg::OFS_RX, 32'h3C96, "rx word");
      rdchk(spp_pkg::OFS_STAT, 32'h1, "rx read clears full");
      rte_s <= 1'b0;
      $display("test sync done");
   endtask

   task t_async;
      wr(spp_pkg::OFS_MODE, 32'h80);
      wr(spp_pkg::OFS_TX, 32'h1234);
      rte_a <= 1'b1;
      cyc(2);
      oechk(6'h3F, "async idle inputs");
      frame(16'h5AA5);
      rdchk(spp_pkg::OFS_RX, 32'h5AA5, "async rx word");
      rdchk(spp_pkg::OFS_STAT, 32'h0, "tx waits for bit clock");
      frame(16'h0F0F);
      frame(16'hF00F);
      rdchk(spp_pkg::OFS_STAT, 32'h6, "overrun flagged");
      wr(spp_pkg::OFS_STAT, 32'h4);
      rdchk(spp_pkg::OFS_RX, 32'hF00F, "newest word kept");
      rdchk(spp_pkg::OFS_STAT, 32'h0, "overrun cleared");
      rte_a <= 1'b0;
      $display("test async done");
   endtask

   task measure(input int b, output int hi, output int per);
      hi = 0;
      while (pout[b] !== 1'b0) cyc(1);
      while (pout[b] !== 1'b1) cyc(1);
      while (pout[b] === 1'b1) begin
         hi++;
         cyc(1);
      end
      per = hi;
      while (pout[b] !== 1'b1) begin
         per++;
         cyc(1);
      end
   endtask

   task t_intclk;
      int hi;
      int per;
      int d;
      for (int k = 0; k < 2; k++) begin
         d = 2 * k;
         wr(spp_pkg::OFS_MODE, {8'h00, 8'(d), 16'h0087});
         cyc(200);
         measure(3, hi, per);
         chk(32'(hi), 32'(d + 3), "clock half");
         chk(32'(per), 32'(2 * d + 6), "clock period");
         measure(2, hi, per);
         chk(32'(hi), 32'(2 * d + 6), "fs width");
         chk(32'(per), 32'(32 * d + 96), "fs spacing");
         oechk(6'h10, "internal drivers on");
      end
      wr(spp_pkg::OFS_MODE, 32'h0);
      $display("test internal clock done");
   endtask

   task t_flags;
      wr(spp_pkg::OFS_MODE, 32'h1E1);
      cyc(3);
      chk({30'h0, pout[1:0]}, 32'h1, "flag pins");
      chk({30'h0, poe_n[1:0]}, 32'h0, "flag pins driven");
      wr(spp_pkg::OFS_MODE, 32'h2E1);
      cyc(3);
      chk({30'h0, pout[1:0]}, 32'h2, "flag pins swapped");
      wr(spp_pkg::OFS_MODE, 32'h98);
      cyc(3);
      chk({30'h0, poe_n[1:0]}, 32'h0, "async rx clock and sync out");
      wr(spp_pkg::OFS_MODE, 32'h0);
      $display("test flags done");
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #100us;
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish;
   end

   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      cyc(1);
      t_reset;
      t_gpio;
      t_sync;
      t_async;
      t_intclk;
      t_flags;
      tally_and_finish;
   end
endmodule
